// ### rtl/dcf_consts.svh
// constants for the dual-clock flag fifo: pin positions, presets, counts
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// system clock period in ns
`define DCF_CLK_PERIOD_NS 10

// bit positions inside the sampled pin vector
`define DCF_PIN_WCLK 0
`define DCF_PIN_RCLK 1
`define DCF_PIN_WEN 2
`define DCF_PIN_REN 3
`define DCF_PIN_OE 4
`define DCF_PIN_WEXP 5
`define DCF_PIN_REXP 6
`define DCF_PIN_LSEL 7
`define DCF_PIN_DATA 8

// system cycles after reset release before the configuration pins are taken
`define DCF_CFG_SETTLE 2'h3

// default partial-flag offsets in words
`define DCF_AE_OFFSET_DEF 1
`define DCF_AF_OFFSET_DEF 1

// reset and preset values of the flag stage chains and of the pin samples
`define DCF_STG_RESET 3'h0
`define DCF_SPACE_STD_PRESET 3'h7
`define DCF_SPACE_PASS_PRESET 3'h0
`define DCF_PIN_RESET 1'h1

`endif

// ### rtl/dcf_pkg.sv
// types shared by the dual-clock flag fifo
package dcf_pkg;

  typedef enum logic [1:0] {
    DCF_STG_ONE,
    DCF_STG_TWO,
    DCF_STG_THREE
  } dcf_depth_t;

  typedef enum logic {
    DCF_CFG_WAIT,
    DCF_CFG_RUN
  } dcf_cfg_state_t;

  typedef struct packed {
    logic pass;
    logic sync_pf;
    dcf_depth_t empty_depth;
    dcf_depth_t full_depth;
  } dcf_mode_t;

endpackage

// ### rtl/dcf_stream_if.sv
// valid/ready word stream between the flag logic and its storage
`timescale 1ns/1ps
`default_nettype none

interface dcf_stream_if #(
  parameter int W = 18
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface // dcf_stream_if

`default_nettype wire

// ### rtl/dcf_word_fifo.sv
// small word fifo with parameter width and depth, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dcf_word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  dcf_stream_if.snk push,
  dcf_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;

  wire [AW:0] used = wptr - rptr;
  wire full = (used == (AW+1)'(DEPTH));
  wire empty = (used == '0);
  wire push_fire = push.valid & ~full;
  wire pop_fire = pop.ready & ~empty;

  assign push.ready = ~full;
  assign pop.valid = ~empty;
  assign pop.data = mem[rptr[AW-1:0]];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push_fire) begin
        wptr <= wptr + (AW+1)'(1);
      end
      if (pop_fire) begin
        rptr <= rptr + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push_fire) begin
      mem[wptr[AW-1:0]] <= push.data;
    end
  end
endmodule // dcf_word_fifo

`default_nettype wire

// ### rtl/dcf_flag_fifo.sv
// dual-clock fifo flag logic with configuration taken at reset release
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.svh"

// Functional notes
// - configuration cycle at reset picks single, double or triple flag buffering.
// - buffering applies to empty and full flags only, not partial flags.
// - each buffer stage adds one clock of delay before a flag clears.
// - only the tabled code combinations exist; flags never configured independently.
// - pass-through: output-ready triple, input-ready double; 001 async, 101 sync partials.
// - standard: 000/100 single, 010/110 double; leading bit picks partial timing.
// - standard timing for codes 000, 011, 100 and 111.
// - read and write clocks may be asynchronous or coincident.
// - pass-through input-ready goes active on a write edge after reset.
// - after reset data outputs low when enabled, released when disabled.
// - read edge too close before write edge defers full change one write edge.
// - write edge too close before read edge defers empty change one read edge.
// - standard mode first word readable the read cycle after empty clears.
// - first-word latency only at empty boundary, one, two or three clocks.
// - async almost-empty asserts on read edge, clears on write edge.
// - async partial timing for codes 000, 001, 010, 011 and 111.
// - async almost-full asserts on write edge, clears on read edge.
// - sync partial flags update only on their own clock's rising edge.
module dcf_flag_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4,
  parameter int AE_OFFSET = `DCF_AE_OFFSET_DEF,
  parameter int AF_OFFSET = `DCF_AF_OFFSET_DEF
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic write_clk_i,
  input wire logic read_clk_i,
  input wire logic write_en_n_i,
  input wire logic read_en_n_i,
  input wire logic out_en_n_i,
  input wire logic first_load_select_n_i,
  input wire logic read_expansion_in_n_i,
  input wire logic write_expansion_in_n_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] q_o,
  output logic q_oe_o,
  output logic empty_indicator_n_o,
  output logic full_indicator_n_o,
  output logic almost_empty_ind_n_o,
  output logic almost_full_ind_n_o,
  output logic passthrough_mode_o,
  output logic sync_partial_o,
  output logic config_done_o
);
  localparam int PW = WIDTH + `DCF_PIN_DATA;
  localparam int CW = $clog2(DEPTH + 2);
  localparam logic [CW-1:0] AE_T = CW'(AE_OFFSET);

  dcf_stream_if #(.W(WIDTH)) push_if ();
  dcf_stream_if #(.W(WIDTH)) pop_if ();

  dcf_word_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_store (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  // three-stage sampling of every pin
  wire [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic [PW-1:0] pin_s3;

  assign pin_raw = {data_i, first_load_select_n_i, read_expansion_in_n_i,
                    write_expansion_in_n_i, out_en_n_i, read_en_n_i,
                    write_en_n_i, read_clk_i, write_clk_i};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= {PW{`DCF_PIN_RESET}};
      pin_s2 <= {PW{`DCF_PIN_RESET}};
      pin_s3 <= {PW{`DCF_PIN_RESET}};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // clock edges count once stages two and three agree
  logic wclk_lvl;
  logic rclk_lvl;
  wire wclk_agree = (pin_s2[`DCF_PIN_WCLK] == pin_s3[`DCF_PIN_WCLK]);
  wire rclk_agree = (pin_s2[`DCF_PIN_RCLK] == pin_s3[`DCF_PIN_RCLK]);
  wire wclk_rise = wclk_agree & pin_s3[`DCF_PIN_WCLK] & ~wclk_lvl;
  wire rclk_rise = rclk_agree & pin_s3[`DCF_PIN_RCLK] & ~rclk_lvl;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wclk_lvl <= 1'h1;
      rclk_lvl <= 1'h1;
    end else begin
      if (wclk_agree) begin
        wclk_lvl <= pin_s3[`DCF_PIN_WCLK];
      end
      if (rclk_agree) begin
        rclk_lvl <= pin_s3[`DCF_PIN_RCLK];
      end
    end
  end

  // configuration decode of the three sampled pins
  wire load_sel = pin_s3[`DCF_PIN_LSEL];
  wire rexp = pin_s3[`DCF_PIN_REXP];
  wire wexp = pin_s3[`DCF_PIN_WEXP];

  wire dec_pass = ~rexp & wexp;
  wire dec_dbl = rexp & ~wexp;
  wire dec_sync = load_sel & ~(rexp & wexp);
  wire dcf_pkg::dcf_depth_t dec_empty_depth =
    dec_pass ? dcf_pkg::DCF_STG_THREE :
    (dec_dbl ? dcf_pkg::DCF_STG_TWO : dcf_pkg::DCF_STG_ONE);
  wire dcf_pkg::dcf_depth_t dec_full_depth =
    (dec_pass | dec_dbl) ? dcf_pkg::DCF_STG_TWO : dcf_pkg::DCF_STG_ONE;
  wire dcf_pkg::dcf_mode_t dec_mode = '{
    pass: dec_pass,
    sync_pf: dec_sync,
    empty_depth: dec_empty_depth,
    full_depth: dec_full_depth
  };

  dcf_pkg::dcf_cfg_state_t state;
  dcf_pkg::dcf_cfg_state_t next_state;
  dcf_pkg::dcf_mode_t mode;
  logic [1:0] settle;

  wire settled = (settle == `DCF_CFG_SETTLE);
  wire capture = (state == dcf_pkg::DCF_CFG_WAIT) & settled;
  wire running = (state == dcf_pkg::DCF_CFG_RUN);

  always_comb begin
    next_state = state;
    case (state)
      dcf_pkg::DCF_CFG_WAIT: begin
        if (settled) begin
          next_state = dcf_pkg::DCF_CFG_RUN;
        end
      end
      dcf_pkg::DCF_CFG_RUN: begin
        next_state = dcf_pkg::DCF_CFG_RUN;
      end
      default: begin
        next_state = dcf_pkg::DCF_CFG_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= dcf_pkg::DCF_CFG_WAIT;
      settle <= 2'h0;
      mode <= '0;
    end else begin
      state <= next_state;
      if (!settled) begin
        settle <= settle + 2'h1;
      end
      if (capture) begin
        mode <= dec_mode;
      end
    end
  end

  // edges count only after the mode is fixed
  wire wr_edge = running & wclk_rise;
  wire rd_edge = running & rclk_rise;
  wire wen = ~pin_s3[`DCF_PIN_WEN];
  wire ren = ~pin_s3[`DCF_PIN_REN];

  logic [2:0] avail_stg;
  logic [2:0] space_stg;
  logic out_valid;
  logic [WIDTH-1:0] q;
  logic [CW-1:0] total;
  logic ae_low;
  logic af_low;

  wire avail_flag = avail_stg[mode.empty_depth];
  wire space_flag = space_stg[mode.full_depth];

  // writes gated by the buffered space flag and by storage back-pressure
  wire push_req = wr_edge & wen & space_flag;
  wire push_fire = push_req & push_if.ready;
  assign push_if.valid = push_req;
  assign push_if.data = pin_s3[PW-1:`DCF_PIN_DATA];

  wire std_pop = rd_edge & ren & avail_flag & ~mode.pass;
  // load at boundary only
  // the third read edge fills the last stage and loads the word on that same edge
  wire pass_due = avail_stg[1] & pop_if.valid;
  wire pass_load = rd_edge & mode.pass & pass_due & (~out_valid | ren);
  wire pass_take = rd_edge & mode.pass & out_valid & ren;
  assign pop_if.ready = std_pop | pass_load;
  wire pop_fire = pop_if.ready & pop_if.valid;
  wire leave = (std_pop & pop_if.valid) | pass_take;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avail_stg <= `DCF_STG_RESET;
    end else if (!pop_if.valid) begin
      avail_stg <= `DCF_STG_RESET;
    end else if (rd_edge) begin
      avail_stg <= {avail_stg[1:0], 1'h1};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      space_stg <= `DCF_STG_RESET;
    end else if (capture) begin
      space_stg <= dec_pass ? `DCF_SPACE_PASS_PRESET : `DCF_SPACE_STD_PRESET;
    end else if (!push_if.ready) begin
      space_stg <= `DCF_STG_RESET;
    end else if (wr_edge) begin
      space_stg <= {space_stg[1:0], 1'h1};
    end
  end

  // output word register and its pass-through valid bit
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid <= 1'h0;
    end else if (pop_fire & mode.pass) begin
      out_valid <= 1'h1;
    end else if (pass_take) begin
      out_valid <= 1'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (pop_fire) begin
      q <= pop_if.data;
    end
  end

  // words held by the device, including the pass-through output word
  wire [CW-1:0] next_total = total + CW'(push_fire) - CW'(leave);
  wire [CW-1:0] cap = CW'(DEPTH) + CW'(mode.pass);
  wire [CW-1:0] af_thr = cap - CW'(AF_OFFSET);
  wire ae_hit = (next_total <= AE_T);
  wire af_hit = (next_total >= af_thr);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      total <= '0;
    end else begin
      total <= next_total;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ae_low <= 1'h1;
    end else if (mode.sync_pf) begin
      if (rd_edge) begin
        ae_low <= ae_hit;
      end
    end else if (rd_edge & ae_hit) begin
      ae_low <= 1'h1;
    end else if (wr_edge & ~ae_hit) begin
      ae_low <= 1'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      af_low <= 1'h0;
    end else if (mode.sync_pf) begin
      if (wr_edge) begin
        af_low <= af_hit;
      end
    end else if (wr_edge & af_hit) begin
      af_low <= 1'h1;
    end else if (rd_edge & ~af_hit) begin
      af_low <= 1'h0;
    end
  end

  // pins: empty/output-ready and full/input-ready share one pin each
  assign empty_indicator_n_o = mode.pass ? ~out_valid : avail_flag;
  assign full_indicator_n_o = mode.pass ? ~space_flag : space_flag;
  assign almost_empty_ind_n_o = ~ae_low;
  assign almost_full_ind_n_o = ~af_low;
  assign q_oe_o = ~pin_s3[`DCF_PIN_OE];
  assign q_o = q;
  assign passthrough_mode_o = mode.pass;
  assign sync_partial_o = mode.sync_pf;
  assign config_done_o = running;

endmodule // dcf_flag_fifo

`default_nettype wire

// ### verif/dcf_port_agent.sv
// writer or reader port model: port clock runs only inside a transfer
`timescale 1ns/1ps
`default_nettype none
module dcf_port_agent (
  input wire logic mclk_i,
  output logic clk_o,
  output logic en_n_o,
  output logic [17:0] data_o
);
  initial begin
    clk_o = 1'h0;
    en_n_o = 1'h1;
    data_o = 18'h0;
  end
  // one port clock period of 16 system cycles, word held past the rising edge
  task automatic cycle(input logic en, input logic [17:0] d);
    @(negedge mclk_i);
    en_n_o = !en;
    data_o = d;
    repeat (4) @(negedge mclk_i);
    clk_o = 1'h1;
    repeat (8) @(negedge mclk_i);
    clk_o = 1'h0;
    repeat (3) @(negedge mclk_i);
    en_n_o = 1'h1;
    data_o = ~d;
  endtask
endmodule // dcf_port_agent
`default_nettype wire

// ### verif/dcf_flag_fifo_properties.sv
// pin-level assertions for the dual-clock flag fifo
`timescale 1ns/1ps
`default_nettype none
module dcf_flag_fifo_properties #(
  parameter int WIDTH = 18
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic write_clk_i,
  input wire logic read_clk_i,
  input wire logic out_en_n_i,
  input wire logic first_load_select_n_i,
  input wire logic read_expansion_in_n_i,
  input wire logic write_expansion_in_n_i,
  input wire logic [WIDTH-1:0] q_o,
  input wire logic q_oe_o,
  input wire logic empty_indicator_n_o,
  input wire logic full_indicator_n_o,
  input wire logic almost_empty_ind_n_o,
  input wire logic almost_full_ind_n_o,
  input wire logic passthrough_mode_o,
  input wire logic sync_partial_o,
  input wire logic config_done_o
);
  localparam int AGE_MAX = 8;
  logic rd_q;
  logic wr_q;
  logic [3:0] rd_age;
  logic [3:0] wr_age;
  // system cycles since each port clock last rose, saturating
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q <= 1'h0;
      wr_q <= 1'h0;
      rd_age <= 4'hf;
      wr_age <= 4'hf;
    end else begin
      rd_q <= read_clk_i;
      wr_q <= write_clk_i;
      rd_age <= (read_clk_i && !rd_q) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
      wr_age <= (write_clk_i && !wr_q) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence cfg_taken;
    $rose(config_done_o);
  endsequence
  sequence oe_on;
    !out_en_n_i [*5];
  endsequence
  sequence oe_off;
    out_en_n_i [*5];
  endsequence
  pass_decode_a: assert property (cfg_taken |-> passthrough_mode_o == (!read_expansion_in_n_i && write_expansion_in_n_i))
    else $error("pass-through mode decode wrong");
  sync_decode_a: assert property (cfg_taken |->
    sync_partial_o == (first_load_select_n_i && !(read_expansion_in_n_i && write_expansion_in_n_i)))
    else $error("partial flag timing decode wrong");
  mode_fixed_a: assert property (config_done_o && $past(config_done_o) |->
    $stable(passthrough_mode_o) && $stable(sync_partial_o)) else $error("mode changed after capture");
  reset_state_a: assert property (disable iff (1'b0) !rst_n_i |-> q_o == '0 && !q_oe_o && !config_done_o)
    else $error("outputs not cleared in reset");
  oe_drive_a: assert property (oe_on |-> q_oe_o) else $error("data bus not driven");
  oe_release_a: assert property (oe_off |-> !q_oe_o) else $error("data bus not released");
  ae_fall_a: assert property (config_done_o && $fell(almost_empty_ind_n_o) |-> rd_age <= AGE_MAX)
    else $error("almost empty set away from read edge");
  ae_rise_a: assert property (config_done_o && $rose(almost_empty_ind_n_o) |->
    (sync_partial_o ? rd_age : wr_age) <= AGE_MAX) else $error("almost empty cleared on wrong edge");
  af_fall_a: assert property ($fell(almost_full_ind_n_o) |-> wr_age <= AGE_MAX)
    else $error("almost full set away from write edge");
  af_rise_a: assert property (config_done_o && $rose(almost_full_ind_n_o) |->
    (sync_partial_o ? wr_age : rd_age) <= AGE_MAX) else $error("almost full cleared on wrong edge");
  full_fall_a: assert property (!passthrough_mode_o && $fell(full_indicator_n_o) |-> wr_age <= AGE_MAX)
    else $error("full set away from write edge");
  empty_fall_a: assert property (!passthrough_mode_o && $fell(empty_indicator_n_o) |-> rd_age <= AGE_MAX)
    else $error("empty set away from read edge");
endmodule // dcf_flag_fifo_properties
bind dcf_flag_fifo dcf_flag_fifo_properties #(.WIDTH(WIDTH)) i_props (.mclk_i, .rst_n_i, .write_clk_i,
  .read_clk_i, .out_en_n_i, .first_load_select_n_i, .read_expansion_in_n_i, .write_expansion_in_n_i,
  .q_o, .q_oe_o, .empty_indicator_n_o, .full_indicator_n_o, .almost_empty_ind_n_o, .almost_full_ind_n_o,
  .passthrough_mode_o, .sync_partial_o, .config_done_o);
`default_nettype wire

// ### verif/dcf_flag_fifo_bench.sv
// self-checking bench for the dual-clock flag fifo
`timescale 1ns/1ps
`default_nettype none
module dcf_flag_fifo_bench;
  logic mclk = 1'h0;
  logic rst_n = 1'h1;
  logic oe_n = 1'h0;
  logic flip = 1'h0;
  logic [2:0] code = 3'h0;
  logic wclk, rclk, wen_n, ren_n, q_oe, empty_n, full_n, ae_n, af_n, pass, sync, done;
  logic [17:0] wdata, q;
  logic pass_e, sync_e, dbl;
  int miscompares = 0;
  int samples_checked = 0;
  always #5 mclk = ~mclk;
  dcf_flag_fifo #(.WIDTH(18), .DEPTH(4)) i_dcf_flag_fifo (
    .mclk_i(mclk), .rst_n_i(rst_n), .write_clk_i(wclk), .read_clk_i(rclk),
    .write_en_n_i(wen_n), .read_en_n_i(ren_n), .out_en_n_i(oe_n),
    .first_load_select_n_i(code[2] ^ flip), .read_expansion_in_n_i(code[1]),
    .write_expansion_in_n_i(code[0]), .data_i(wdata), .q_o(q), .q_oe_o(q_oe),
    .empty_indicator_n_o(empty_n), .full_indicator_n_o(full_n), .almost_empty_ind_n_o(ae_n),
    .almost_full_ind_n_o(af_n), .passthrough_mode_o(pass), .sync_partial_o(sync), .config_done_o(done));
  dcf_port_agent i_writer (.mclk_i(mclk), .clk_o(wclk), .en_n_o(wen_n), .data_o(wdata));
  dcf_port_agent i_reader (.mclk_i(mclk), .clk_o(rclk), .en_n_o(ren_n), .data_o());
  function automatic logic [17:0] word(input int i);
    return 18'h2a5c0 + 18'(i);
  endfunction
  task automatic check(input string what, input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("counts: %0d checked, %0d unexpected", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic boot(input logic [2:0] c);
    int n;
    @(negedge mclk);
    rst_n = 1'h0;
    // code pins set per run; load-select later toggled through flip
    code = c;
    repeat (6) @(negedge mclk);
    rst_n = 1'h1;
    n = 0;
    while (done !== 1'h1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    check("done", 18'(done), 18'h1);
    repeat (4) @(negedge mclk);
  endtask
  task automatic std_test;
    i_writer.cycle(1'h1, word(0));
    check("empty0", 18'(empty_n), 18'h0);
    i_reader.cycle(1'h0, 18'h0);
    check("empty1", 18'(empty_n), 18'(!dbl));
    i_reader.cycle(1'h0, 18'h0);
    check("empty2", 18'(empty_n), 18'h1);
    for (int i = 1; i < 5; i++) begin
      i_writer.cycle(1'h1, word(i));
    end
    check("fill", 18'({full_n, af_n, ae_n}), 18'(!sync_e));
    i_reader.cycle(1'h1, 18'h0);
    check("q0", q, word(0));
    i_writer.cycle(1'h0, 18'h0);
    check("full1", 18'(full_n), 18'(!dbl));
    i_writer.cycle(1'h0, 18'h0);
    check("full2", 18'(full_n), 18'h1);
    for (int i = 1; i < 5; i++) begin
      i_reader.cycle(1'h1, 18'h0);
      check("qn", q, word(i < 4 ? i : 3));
    end
    check("drain", 18'({empty_n, ae_n}), 18'h0);
  endtask
  task automatic pass_test;
    check("ir0", 18'(full_n), 18'h1);
    i_writer.cycle(1'h0, 18'h0);
    check("ir1", 18'(full_n), 18'h1);
    i_writer.cycle(1'h0, 18'h0);
    check("ir2", 18'(full_n), 18'h0);
    i_writer.cycle(1'h1, word(7));
    i_reader.cycle(1'h0, 18'h0);
    i_reader.cycle(1'h0, 18'h0);
    check("or2", 18'(empty_n), 18'h1);
    i_reader.cycle(1'h0, 18'h0);
    check("or3", 18'(empty_n), 18'h0);
    check("qp", q, word(7));
  endtask
  initial begin
    for (int c = 0; c < 8; c++) begin
      boot(3'(c));
      pass_e = (c == 1 || c == 5);
      sync_e = c inside {4, 5, 6};
      dbl = (c == 2 || c == 6);
      check("mode", 18'({pass, sync}), 18'({pass_e, sync_e}));
      check("q", q, 18'h0);
      check("oe", 18'(q_oe), 18'h1);
      oe_n = 1'h1;
      flip = 1'h1;
      repeat (8) @(negedge mclk);
      check("hiz", 18'(q_oe), 18'h0);
      check("hold", 18'({pass, sync}), 18'({pass_e, sync_e}));
      oe_n = 1'h0;
      flip = 1'h0;
      repeat (8) @(negedge mclk);
      if (pass_e) begin
        pass_test();
      end else begin
        std_test();
      end
      $display("test code %0d done", c);
    end
    test_done();
  end
  initial begin
    #300000;
    miscompares++;
    test_done();
  end
endmodule // dcf_flag_fifo_bench
`default_nettype wire
